// ===== logic/kdtg_pkg.sv
// package of constants for the keypad dual tone generator
package kdtg_pkg;

  // ==========================================================
  // clocking and keypad geometry
  localparam int CLK_HZ = 50000000;
  localparam int NUM_ROWS = 4;
  localparam int NUM_COLS = 4;
  localparam int SYNC_STAGES = 3;

  // ==========================================================
  // sine converter steps and code layout
  localparam int SINE_STEPS = 28;
  localparam int HALF_STEPS = SINE_STEPS / 2;
  localparam int QUART_STEPS = SINE_STEPS / 4;
  localparam int PHASE_W = 5;
  localparam int CODE_W = 8;
  localparam int DIV_W = 12;
  localparam int LEVEL_W = 10;
  localparam logic [PHASE_W-1:0] PHASE_LAST = 5'h1B;

  // ==========================================================
  // tone frequencies in hz, low group by row, high group by column
  localparam int LOW_HZ_R0 = 697;
  localparam int LOW_HZ_R1 = 770;
  localparam int LOW_HZ_R2 = 852;
  localparam int LOW_HZ_R3 = 941;
  localparam int HIGH_HZ_C0 = 1209;
  localparam int HIGH_HZ_C1 = 1336;
  localparam int HIGH_HZ_C2 = 1477;
  localparam int HIGH_HZ_C3 = 1633;

  // clock cycles per sine step, rounded to nearest
  function automatic logic [DIV_W-1:0] step_div(input int hz);
    int d;
    d = (CLK_HZ + (hz * SINE_STEPS) / 2) / (hz * SINE_STEPS);
    return d[DIV_W-1:0];
  endfunction

  localparam logic [DIV_W-1:0] LOW_DIV_R0 = step_div(LOW_HZ_R0);
  localparam logic [DIV_W-1:0] LOW_DIV_R1 = step_div(LOW_HZ_R1);
  localparam logic [DIV_W-1:0] LOW_DIV_R2 = step_div(LOW_HZ_R2);
  localparam logic [DIV_W-1:0] LOW_DIV_R3 = step_div(LOW_HZ_R3);
  localparam logic [DIV_W-1:0] HIGH_DIV_C0 = step_div(HIGH_HZ_C0);
  localparam logic [DIV_W-1:0] HIGH_DIV_C1 = step_div(HIGH_HZ_C1);
  localparam logic [DIV_W-1:0] HIGH_DIV_C2 = step_div(HIGH_HZ_C2);
  localparam logic [DIV_W-1:0] HIGH_DIV_C3 = step_div(HIGH_HZ_C3);

  // ==========================================================
  // output levels and reset values
  localparam logic [LEVEL_W-1:0] IDLE_OFFSET_LEVEL = 10'h200;
  localparam logic [LEVEL_W-1:0] LEVEL_OFF = 10'h000;
  localparam logic [CODE_W-1:0] CODE_ZERO = 8'h00;
  localparam logic [DIV_W-1:0] DIV_RESET = 12'h000;

  // generator states
  typedef enum logic [1:0] {
    KDTG_IDLE,
    KDTG_HOLD,
    KDTG_TONE
  } kdtg_state_type;

endpackage

// ===== logic/kdtg_sync.sv
// three-stage level synchroniser with agreement filter
`timescale 1ns/1ps

module kdtg_sync #(
  parameter int WIDTH = 4,
  parameter logic [WIDTH-1:0] RESET_VAL = '1
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // asynchronous levels and filtered result
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  // ==========================================================
  // per-bit chain
  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi++) begin : g_bit
      logic s1_r;
      logic s2_r;
      logic s3_r;
      logic out_r;
      // first stage feeds only the second
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          s1_r <= RESET_VAL[gi];
          s2_r <= RESET_VAL[gi];
          s3_r <= RESET_VAL[gi];
        end else begin
          s1_r <= async_in[gi];
          s2_r <= s1_r;
          s3_r <= s2_r;
        end
      end
      // accept a change only once two later stages agree
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          out_r <= RESET_VAL[gi];
        end else if (s2_r == s3_r) begin
          out_r <= s3_r;
        end
      end
      assign sync_out[gi] = out_r;
    end
  endgenerate

endmodule // kdtg_sync

// ===== logic/kdtg_tone.sv
// one tone group: programmable step divider and 28-step sine table
`timescale 1ns/1ps

module kdtg_tone
  import kdtg_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // control
  input wire logic run,
  input wire logic [DIV_W-1:0] div_ratio,
  // sine code, two's complement, and step pulse
  output logic [CODE_W-1:0] code_r,
  output logic step_r
);

  logic [DIV_W-1:0] cnt_r;
  logic [PHASE_W-1:0] phase_r;
  logic wrap;

  // quarter wave magnitude, amplitude 100
  function automatic logic [CODE_W-1:0] quarter(input logic [PHASE_W-1:0] q);
    case (q)
      5'h00: quarter = 8'h00;
      5'h01: quarter = 8'h16;
      5'h02: quarter = 8'h2B;
      5'h03: quarter = 8'h3E;
      5'h04: quarter = 8'h4E;
      5'h05: quarter = 8'h5A;
      5'h06: quarter = 8'h61;
      5'h07: quarter = 8'h64;
      default: quarter = 8'h00;
    endcase
  endfunction

  // fold a full-cycle phase into sign and quarter index
  function automatic logic [CODE_W-1:0] sine(input logic [PHASE_W-1:0] p);
    logic [PHASE_W-1:0] h;
    logic [PHASE_W-1:0] q;
    logic [CODE_W-1:0] m;
    h = (p >= PHASE_W'(HALF_STEPS)) ? p - PHASE_W'(HALF_STEPS) : p;
    q = (h > PHASE_W'(QUART_STEPS)) ? PHASE_W'(HALF_STEPS) - h : h;
    m = quarter(q);
    sine = (p >= PHASE_W'(HALF_STEPS)) ? CODE_W'(~m + 8'h01) : m;
  endfunction

  assign wrap = (cnt_r >= div_ratio - 12'h001);

  // ==========================================================
  // step divider, held cleared while stopped so each start is in phase
  always_ff @(posedge clk) begin
    if (!rst_n || !run) begin
      cnt_r <= DIV_RESET;
    end else if (wrap) begin
      cnt_r <= DIV_RESET;
    end else begin
      cnt_r <= cnt_r + 12'h001;
    end
  end

  // phase walks 28 equal steps per cycle
  always_ff @(posedge clk) begin
    if (!rst_n || !run) begin
      phase_r <= '0;
      step_r <= 1'b0;
    end else begin
      step_r <= wrap;
      if (wrap) begin
        phase_r <= (phase_r == PHASE_LAST) ? '0 : phase_r + 5'h01; // RL10
      end
    end
  end

  // table code registered, refreshed each step
  always_ff @(posedge clk) begin
    if (!rst_n || !run) begin
      code_r <= CODE_ZERO;
    end else begin
      code_r <= sine(phase_r); // RL16
    end
  end

endmodule // kdtg_tone

// ===== logic/kdtg_top.sv
// keypad dual tone generator top: key sensing, tone selection and mixing
`timescale 1ns/1ps

//
// Contract
// [RL1] key valid only with exactly one row and one column low; then start tones
// [RL2] key inputs sensed statically as levels, no scanning; logic levels allowed
// [RL3] with no key active, oscillator stopped and output stage off
// [RL4] column activity without a valid combination keeps the oscillator stopped
// [RL5] tone disable low stops oscillator, output open; high gives normal tones
// [RL6] mute low whenever any key is sensed, regardless of single tone inhibit
// [RL7] inhibit low: single-frequency combinations give no tone, others unchanged
// [RL8] inhibit high: rows-many gives high tone, columns-many low tone, both none
// [RL9] valid press loads both group counters with ratios of its row and column
// [RL10] each group steps its sine converter through 28 equal steps per cycle
// [RL11] rows map to 697..941 hz, columns to 1209..1633 hz
// [RL12] all tone timing derived from the reference clock
// [RL13] output sums both tones, high group emphasised by about 2.7 db
// [RL14] suppressed tone while a key is active holds idle offset, mute asserted
// [RL15] don't-care inputs have no effect in their table rows
// [RL16] each tone presented as sine table codes updated every counter step
// [RL17] single reference clock, tone logic halted while no valid key
module kdtg_top
  import kdtg_pkg::*;
#(
  parameter int ROWS = NUM_ROWS,
  parameter int COLS = NUM_COLS
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // keypad lines, active low
  input wire logic [ROWS-1:0] row_line_n,
  input wire logic [COLS-1:0] column_line_n,
  // mode pins
  input wire logic tone_disable_n,
  input wire logic single_tone_allow,
  // status
  output logic mute_n_r,
  output logic osc_run_r,
  output logic stage_on_r,
  // tone codes and summed level
  output logic [CODE_W-1:0] low_code_r,
  output logic [CODE_W-1:0] high_code_r,
  output logic low_step_r,
  output logic high_step_r,
  output logic [LEVEL_W-1:0] tone_level_r
);

  // ==========================================================
  // synchronised inputs
  logic [ROWS-1:0] row_s_n;
  logic [COLS-1:0] col_s_n;
  logic [1:0] mode_s;

  // levels are sampled continuously, which is the static sensing
  kdtg_sync #(.WIDTH(ROWS), .RESET_VAL('1)) u_row_sync ( // RL2
    .clk(clk),
    .rst_n(rst_n),
    .async_in(row_line_n),
    .sync_out(row_s_n)
  );

  kdtg_sync #(.WIDTH(COLS), .RESET_VAL('1)) u_col_sync (
    .clk(clk),
    .rst_n(rst_n),
    .async_in(column_line_n),
    .sync_out(col_s_n)
  );

  // tone disable resets high (pull-up), inhibit resets low (pull-down)
  kdtg_sync #(.WIDTH(2), .RESET_VAL(2'h1)) u_mode_sync (
    .clk(clk),
    .rst_n(rst_n),
    .async_in({single_tone_allow, tone_disable_n}),
    .sync_out(mode_s)
  );

  // ==========================================================
  // key decode
  logic [ROWS-1:0] row_act;
  logic [COLS-1:0] col_act;
  logic row_one;
  logic row_many;
  logic col_one;
  logic col_many;
  logic any_key;
  logic valid_pair;
  logic low_want;
  logic high_want;
  logic tone_on;
  logic [1:0] row_idx;
  logic [1:0] col_idx;

  // count active lines of a group
  function automatic int count_bits(input logic [7:0] v);
    int n;
    n = 0;
    for (int i = 0; i < 8; i++) begin
      n = n + int'(v[i]);
    end
    return n;
  endfunction

  // index of the lowest active line
  function automatic logic [1:0] first_idx(input logic [3:0] v);
    logic [1:0] r;
    r = 2'h0;
    for (int i = 3; i >= 0; i--) begin
      if (v[i]) begin
        r = 2'(i);
      end
    end
    return r;
  endfunction

  assign row_act = ~row_s_n;
  assign col_act = ~col_s_n;
  assign row_one = (count_bits(8'(row_act)) == 1);
  assign row_many = (count_bits(8'(row_act)) > 1);
  assign col_one = (count_bits(8'(col_act)) == 1);
  assign col_many = (count_bits(8'(col_act)) > 1);
  assign any_key = (|row_act) | (|col_act);
  assign valid_pair = row_one & col_one; // RL1
  assign row_idx = first_idx(4'(row_act));
  assign col_idx = first_idx(4'(col_act));

  // group selection; for a valid pair the inhibit pin is ignored
  always_comb begin
    low_want = 1'b0;
    high_want = 1'b0;
    if (valid_pair) begin
      low_want = 1'b1; // RL15
      high_want = 1'b1;
    end else if (mode_s[1]) begin
      low_want = row_one & col_many; // RL8
      high_want = row_many & col_one; // RL8
    end else begin
      low_want = 1'b0; // RL7
      high_want = 1'b0; // RL7
    end
  end

  // disable pin overrides everything else
  assign tone_on = mode_s[0] & (low_want | high_want); // RL5

  // ==========================================================
  // state machine: idle, key held but silent, tone
  kdtg_state_type state_r;
  kdtg_state_type state_nxt;

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      KDTG_IDLE: begin
        if (tone_on) begin
          state_nxt = KDTG_TONE; // RL1
        end else if (any_key) begin
          state_nxt = KDTG_HOLD; // RL4
        end
      end
      KDTG_HOLD: begin
        if (tone_on) begin
          state_nxt = KDTG_TONE;
        end else if (!any_key) begin
          state_nxt = KDTG_IDLE;
        end
      end
      KDTG_TONE: begin
        if (!any_key) begin
          state_nxt = KDTG_IDLE; // RL3
        end else if (!tone_on) begin
          state_nxt = KDTG_HOLD; // RL14
        end
      end
      default: state_nxt = KDTG_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_r <= KDTG_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ==========================================================
  // divide ratios, loaded from the row and column of the press
  logic [DIV_W-1:0] low_div_r;
  logic [DIV_W-1:0] high_div_r;
  logic low_en_r;
  logic high_en_r;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      low_div_r <= DIV_RESET;
      high_div_r <= DIV_RESET;
    end else if (tone_on) begin
      case (row_idx) // RL9
        2'h0: low_div_r <= LOW_DIV_R0; // RL11
        2'h1: low_div_r <= LOW_DIV_R1;
        2'h2: low_div_r <= LOW_DIV_R2;
        default: low_div_r <= LOW_DIV_R3;
      endcase
      case (col_idx)
        2'h0: high_div_r <= HIGH_DIV_C0; // RL11
        2'h1: high_div_r <= HIGH_DIV_C1;
        2'h2: high_div_r <= HIGH_DIV_C2;
        default: high_div_r <= HIGH_DIV_C3;
      endcase
    end
  end

  // per-group run enables follow the decode one cycle later, with the ratios
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      low_en_r <= 1'b0;
      high_en_r <= 1'b0;
    end else begin
      low_en_r <= tone_on & low_want;
      high_en_r <= tone_on & high_want;
    end
  end

  // ==========================================================
  // tone groups; stopped counters stand for the halted oscillator
  logic [CODE_W-1:0] low_code;
  logic [CODE_W-1:0] high_code;
  logic low_step;
  logic high_step;

  kdtg_tone u_low_tone ( // RL12
    .clk(clk),
    .rst_n(rst_n),
    .run(low_en_r), // RL17
    .div_ratio(low_div_r),
    .code_r(low_code),
    .step_r(low_step)
  );

  kdtg_tone u_high_tone (
    .clk(clk),
    .rst_n(rst_n),
    .run(high_en_r), // RL17
    .div_ratio(high_div_r),
    .code_r(high_code),
    .step_r(high_step)
  );

  // ==========================================================
  // mixer: high group scaled by 11/8, about 2.77 db
  logic signed [LEVEL_W:0] low_ext;
  logic signed [LEVEL_W:0] high_ext;
  logic signed [LEVEL_W:0] high_emph;
  logic signed [LEVEL_W:0] mix;

  assign low_ext = (LEVEL_W + 1)'(signed'(low_code));
  assign high_ext = (LEVEL_W + 1)'(signed'(high_code));
  // shifts instead of a multiplier; 0.07 db error is within tolerance
  assign high_emph = high_ext + (high_ext >>> 2) + (high_ext >>> 3); // RL13
  assign mix = signed'({1'b0, IDLE_OFFSET_LEVEL}) + low_ext + high_emph; // RL13

  // summed level; offset alone while holding a key, zero while idle
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tone_level_r <= LEVEL_OFF;
    end else if (state_r == KDTG_TONE) begin
      tone_level_r <= mix[LEVEL_W-1:0];
    end else if (state_r == KDTG_HOLD) begin
      tone_level_r <= IDLE_OFFSET_LEVEL; // RL14
    end else begin
      tone_level_r <= LEVEL_OFF; // RL3
    end
  end

  // ==========================================================
  // status pins
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mute_n_r <= 1'b1;
      osc_run_r <= 1'b0;
      stage_on_r <= 1'b0;
    end else begin
      mute_n_r <= ~any_key; // RL6
      osc_run_r <= (state_r == KDTG_TONE); // RL4
      // stage open when disabled or idle, driven while holding offset
      stage_on_r <= (state_r == KDTG_TONE) | ((state_r == KDTG_HOLD) & mode_s[0]); // RL5
    end
  end

  // registered copies of the group codes for an external converter
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      low_code_r <= CODE_ZERO;
      high_code_r <= CODE_ZERO;
      low_step_r <= 1'b0;
      high_step_r <= 1'b0;
    end else begin
      low_code_r <= low_code; // RL16
      high_code_r <= high_code;
      low_step_r <= low_step;
      high_step_r <= high_step;
    end
  end

endmodule // kdtg_top

// ===== tb/kdtg_keypad.sv
// keypad model: closed keys pull their lines low, open lines float high
`timescale 1ns/1ps

module kdtg_keypad (
  // closed lines, one bit per line
  input wire logic [3:0] row_sel,
  input wire logic [3:0] col_sel,
  // active-low lines toward the generator
  output logic [3:0] row_line_n,
  output logic [3:0] column_line_n
);
  // ==========================================================
  // static levels, pull-ups win on every open line
  assign row_line_n = ~row_sel;
  assign column_line_n = ~col_sel;
endmodule // kdtg_keypad

// ===== tb/kdtg_top_checker.sv
// concurrent checks on the generator top ports
`timescale 1ns/1ps

module kdtg_top_checker
  import kdtg_pkg::*;
#(
  parameter int ROWS = NUM_ROWS,
  parameter int COLS = NUM_COLS
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // inputs and outputs watched
  input wire logic [ROWS-1:0] row_line_n,
  input wire logic [COLS-1:0] column_line_n,
  input wire logic tone_disable_n,
  input wire logic mute_n_r,
  input wire logic osc_run_r,
  input wire logic stage_on_r,
  input wire logic [CODE_W-1:0] low_code_r,
  input wire logic [CODE_W-1:0] high_code_r,
  input wire logic low_step_r,
  input wire logic high_step_r,
  input wire logic [LEVEL_W-1:0] tone_level_r
);
  // ==========================================================
  // one domain, so clock and reset stated once
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  chk_mute_release: assert property ((&row_line_n && &column_line_n) [*6] |=> mute_n_r)
    else $error("mute held with all lines open");
  chk_idle_quiet: assert property (mute_n_r [*3] |-> !osc_run_r && !stage_on_r && tone_level_r == LEVEL_OFF)
    else $error("output active with no key");
  chk_osc_mute: assert property (osc_run_r |-> !$past(mute_n_r))
    else $error("tones without mute");
  chk_stage_osc: assert property (osc_run_r |-> stage_on_r)
    else $error("tones with stage off");
  chk_disable_open: assert property (!tone_disable_n [*7] |=> !stage_on_r && !osc_run_r)
    else $error("disable did not open output");
  chk_hold_offset: assert property (stage_on_r && !osc_run_r |-> tone_level_r == IDLE_OFFSET_LEVEL)
    else $error("hold level not at offset");
  chk_code_stop: assert property (!osc_run_r [*4] |-> low_code_r == CODE_ZERO && high_code_r == CODE_ZERO)
    else $error("codes move while stopped");
  chk_low_pulse: assert property (low_step_r |=> !low_step_r [*8])
    else $error("low step too close");
  chk_high_pulse: assert property (high_step_r |=> !high_step_r [*8])
    else $error("high step too close");
endmodule // kdtg_top_checker

bind kdtg_top kdtg_top_checker #(.ROWS(ROWS), .COLS(COLS)) u_kdtg_top_checker (.clk(clk), .rst_n(rst_n),
  .row_line_n(row_line_n), .column_line_n(column_line_n), .tone_disable_n(tone_disable_n),
  .mute_n_r(mute_n_r), .osc_run_r(osc_run_r), .stage_on_r(stage_on_r), .low_code_r(low_code_r),
  .high_code_r(high_code_r), .low_step_r(low_step_r), .high_step_r(high_step_r), .tone_level_r(tone_level_r));

// ===== tb/test_keypad_dual_tone_generator.sv
// self-checking bench for the keypad dual tone generator
`timescale 1ns/1ps

module test_keypad_dual_tone_generator;
  import kdtg_pkg::*;
  logic clk, rst_n, tone_disable_n, single_tone_allow, mute_n_r, osc_run_r, stage_on_r, low_step_r, high_step_r;
  logic [3:0] row_sel, col_sel, row_line_n, column_line_n;
  logic [CODE_W-1:0] low_code_r, high_code_r, c0;
  logic [LEVEL_W-1:0] tone_level_r;
  int miscompares = 0;
  int comparisons = 0;
  int n, chg;
  int low_div[4] = '{2562, 2319, 2096, 1898};
  int high_div[4] = '{1477, 1337, 1209, 1094};

  // ==========================================================
  // keypad model and generator
  kdtg_keypad u_kdtg_keypad (.row_sel(row_sel), .col_sel(col_sel), .row_line_n(row_line_n),
    .column_line_n(column_line_n));
  kdtg_top u_kdtg_top (.clk(clk), .rst_n(rst_n), .row_line_n(row_line_n), .column_line_n(column_line_n),
    .tone_disable_n(tone_disable_n), .single_tone_allow(single_tone_allow), .mute_n_r(mute_n_r),
    .osc_run_r(osc_run_r), .stage_on_r(stage_on_r), .low_code_r(low_code_r), .high_code_r(high_code_r),
    .low_step_r(low_step_r), .high_step_r(high_step_r), .tone_level_r(tone_level_r));

  // ==========================================================
  // shared tasks
  task automatic stop_test();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // inputs change on a rising edge; sync latency is well under 12 cycles
  task automatic set_in(input logic [3:0] r, input logic [3:0] c, input logic a, input logic d);
    @(posedge clk);
    row_sel <= r;
    col_sel <= c;
    single_tone_allow <= a;
    tone_disable_n <= d;
    repeat (12) @(negedge clk);
  endtask

  task automatic st(input logic m, input logic o, input logic s);
    cmp({13'h0000, mute_n_r, osc_run_r, stage_on_r}, {13'h0000, m, o, s});
  endtask

  // cycles to the next step pulse, sampled on the falling edge
  task automatic next_step(input logic hi, output int k);
    k = 1;
    @(negedge clk);
    while ((hi ? high_step_r : low_step_r) !== 1'b1 && k < 6000) begin
      @(negedge clk);
      k++;
    end
  endtask

  task automatic gap(input logic hi, input int exp);
    next_step(hi, n);
    next_step(hi, n);
    cmp(16'(n), 16'(exp));
  endtask

  // high group swing about the offset against its own code, 2.2 to 3.2 db window
  task automatic emph();
    int h;
    int d;
    h = int'(signed'(high_code_r));
    d = int'(tone_level_r) - int'(IDLE_OFFSET_LEVEL);
    if (h < 0) begin
      h = -h;
      d = -d;
    end
    cmp(16'(1000 * d >= 1288 * h && 1000 * d <= 1445 * h + 1000), 16'h0001);
  endtask

  // ==========================================================
  // clock and watchdog
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // whole run is about 72k cycles, so 95k cycles means a hang
  initial begin
    #1900000;
    miscompares++;
    stop_test();
  end

  // ==========================================================
  // test sequence
  initial begin
    rst_n = 1'b0;
    row_sel = 4'h0;
    col_sel = 4'h0;
    tone_disable_n = 1'b1;
    single_tone_allow = 1'b0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    repeat (8) @(negedge clk);
    st(1'b1, 1'b0, 1'b0);
    cmp(16'(tone_level_r), 16'(LEVEL_OFF));
    $display("test idle done");
    // inhibit setting alternates: it must not matter for a valid pair
    for (int i = 0; i < 4; i++) begin
      set_in(4'(1 << i), 4'(1 << i), i[0], 1'b1);
      st(1'b0, 1'b1, 1'b1);
      gap(1'b0, low_div[i]);
      gap(1'b1, high_div[i]);
    end
    $display("test pairs done");
    next_step(1'b1, n);
    c0 = high_code_r;
    chg = 0;
    repeat (28) begin
      next_step(1'b1, n);
      if (high_code_r !== c0) chg = 1;
    end
    cmp(16'(high_code_r), 16'(c0));
    cmp(16'(chg), 16'h0001);
    $display("test cycle done");
    // row and column indices differ, so a swapped decode shows
    set_in(4'h8, 4'h1, 1'b0, 1'b1);
    gap(1'b0, low_div[3]);
    gap(1'b1, high_div[0]);
    $display("test cross done");
    set_in(4'h1, 4'h2, 1'b1, 1'b0);
    st(1'b0, 1'b0, 1'b0);
    cmp(16'(tone_level_r), 16'(IDLE_OFFSET_LEVEL));
    set_in(4'h3, 4'h1, 1'b0, 1'b1);
    st(1'b0, 1'b0, 1'b1);
    cmp(16'(tone_level_r), 16'(IDLE_OFFSET_LEVEL));
    set_in(4'h3, 4'h1, 1'b1, 1'b1);
    gap(1'b1, high_div[0]);
    cmp(16'(low_code_r), 16'(CODE_ZERO));
    repeat (4) begin
      next_step(1'b1, n);
      emph();
    end
    set_in(4'h1, 4'h5, 1'b1, 1'b1);
    gap(1'b0, low_div[0]);
    cmp(16'(high_code_r), 16'(CODE_ZERO));
    cmp(16'(tone_level_r), 16'(int'(IDLE_OFFSET_LEVEL) + int'(signed'(low_code_r))));
    set_in(4'h3, 4'h5, 1'b1, 1'b1);
    st(1'b0, 1'b0, 1'b1);
    cmp(16'(tone_level_r), 16'(IDLE_OFFSET_LEVEL));
    set_in(4'h0, 4'h4, 1'b1, 1'b1);
    st(1'b0, 1'b0, 1'b1);
    set_in(4'h0, 4'h0, 1'b0, 1'b1);
    st(1'b1, 1'b0, 1'b0);
    cmp(16'(tone_level_r), 16'(LEVEL_OFF));
    $display("test modes done");
    stop_test();
  end
endmodule // test_keypad_dual_tone_generator
